// ===== light_sensor_i2c_register_port.sv
// Notes on behaviour
// - acts as serial slave on a 7-bit address, standard and fast clock rates
// - an 8-bit register pointer picks the byte for the next transfer
// - pointer steps by one after every data byte, either direction
// - pointer survives stop conditions and idle bus
// - reads without a pointer byte continue after the last register touched
// - reading a low byte latches the pair; high byte read returns latched half
// - device drives acknowledge on the ninth clock after its own address and each written byte
// - master acks all but last byte; device keeps sending while acked
// - integration timer advances in 2.78 ms steps from internal clock
// - gain choices are 1x, 4x, 16x, 64x and 128x
// - fourth result pair holds X or second infrared by selection
// - register 0x80 enables operating states: power-on in bit 0, measurement in bit 1
// - power-on bit runs the internal timebase; clearing stops it
// - integration down counter from length to zero, N+1 steps
`default_nettype none
`include "light_sensor_defines.svh"
module light_sensor_i2c_register_port
   import light_sensor_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h2A,
   // arbitrary identification values
   parameter logic [7:0] REVISION_VALUE = 8'h5A,
   parameter logic [7:0] PART_VALUE = 8'hA5,
   parameter int STEP_CYCLES = $rtoi(`INTEG_STEP_MS * 1000.0 * `SYS_CLK_MHZ)
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // serial link
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // converter results
   input wire logic [15:0] i_z_result,
   input wire logic [15:0] i_y_result,
   input wire logic [15:0] i_infrared_one,
   input wire logic [15:0] i_x_result,
   input wire logic [15:0] i_second_infrared_channel,
   // measurement control
   output logic o_osc_run,
   output logic o_integrating,
   output logic o_capture,
   output logic [2:0] o_analog_gain_select
);
   import light_sensor_pkg::*;

   // ************************************************
   // pin synchronisers and timer
   // ************************************************
   logic scl_s;
   logic sda_s;
   step_timer_if tif ();

   // both pins see the same flop depth, so their relative order is kept
   sync_two_flop #(.RESET_LEVEL(1'b1)) u_sync_scl (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async(i_scl),
      .o_sync(scl_s)
   );
   sync_two_flop #(.RESET_LEVEL(1'b1)) u_sync_sda (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async(i_sda),
      .o_sync(sda_s)
   );
   step_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .tif(tif)
   );

   port_state_t s_r;
   port_state_t s_nxt;

   // ************************************************
   // register read and write
   // ************************************************
   // unmapped offsets read as zero rather than floating
   function automatic logic [7:0] reg_read(input port_state_t s, input logic [7:0] a,
                                           input logic busy);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `OFS_STATE_ENABLE: d = s.state_enable;
         `OFS_INTEGRATION_LENGTH: d = s.integration_length;
         `OFS_IDLE_GAP_LENGTH: d = s.idle_gap_length;
         `OFS_LOW_THRESHOLD_LSB: d = s.low_threshold[7:0];
         `OFS_HIGH_THRESHOLD_LSB: d = s.high_threshold[7:0];
         `OFS_ALERT_FILTER_COUNT: d = s.alert_filter_count;
         `OFS_SETUP_ZERO: d = s.setup_zero;
         `OFS_SETUP_ONE: d = s.setup_one;
         `OFS_REVISION_CODE: d = REVISION_VALUE;
         `OFS_PART_CODE: d = PART_VALUE;
         `OFS_DEVICE_STATUS: d = {6'h00, busy, s.valid};
         `OFS_Z_RESULT_LSB: d = s.res_z[7:0];
         `OFS_Y_RESULT_LSB: d = s.res_y[7:0];
         `OFS_INFRARED_ONE_LSB: d = s.res_ir1[7:0];
         `OFS_X_OR_INFRARED_TWO_LSB: d = s.res_ch4[7:0];
         // high halves come from the latch filled by the low-byte read
         `OFS_LOW_THRESHOLD_MSB, `OFS_HIGH_THRESHOLD_MSB, `OFS_Z_RESULT_MSB,
         `OFS_Y_RESULT_MSB, `OFS_INFRARED_ONE_MSB,
         `OFS_X_OR_INFRARED_TWO_MSB: d = s.read_latch;
         `OFS_SETUP_TWO: d = s.setup_two;
         `OFS_SETUP_THREE: d = s.setup_three;
         `OFS_OFFSET_CANCEL_SETUP: d = s.offset_cancel_setup;
         `OFS_INTERRUPT_MASK_BITS: d = s.interrupt_mask_bits;
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // low-byte reads freeze the whole pair so a later update cannot tear it
   function automatic port_state_t latch_pair(input port_state_t s, input logic [7:0] a);
      port_state_t n;
      n = s;
      case (a)
         `OFS_LOW_THRESHOLD_LSB: n.read_latch = s.low_threshold[15:8];
         `OFS_HIGH_THRESHOLD_LSB: n.read_latch = s.high_threshold[15:8];
         `OFS_Z_RESULT_LSB: n.read_latch = s.res_z[15:8];
         `OFS_Y_RESULT_LSB: n.read_latch = s.res_y[15:8];
         `OFS_INFRARED_ONE_LSB: n.read_latch = s.res_ir1[15:8];
         `OFS_X_OR_INFRARED_TWO_LSB: n.read_latch = s.res_ch4[15:8];
         default: n.read_latch = s.read_latch;
      endcase
      return n;
   endfunction

   function automatic port_state_t reg_write(input port_state_t s, input logic [7:0] a,
                                             input logic [7:0] d);
      port_state_t n;
      n = s;
      case (a)
         `OFS_STATE_ENABLE: n.state_enable = d;
         `OFS_INTEGRATION_LENGTH: n.integration_length = d;
         `OFS_IDLE_GAP_LENGTH: n.idle_gap_length = d;
         // two-byte thresholds commit only when the high byte arrives
         `OFS_LOW_THRESHOLD_LSB: n.write_hold = d;
         `OFS_LOW_THRESHOLD_MSB: n.low_threshold = {d, s.write_hold};
         `OFS_HIGH_THRESHOLD_LSB: n.write_hold = d;
         `OFS_HIGH_THRESHOLD_MSB: n.high_threshold = {d, s.write_hold};
         `OFS_ALERT_FILTER_COUNT: n.alert_filter_count = d;
         `OFS_SETUP_ZERO: n.setup_zero = d;
         `OFS_SETUP_ONE: n.setup_one = d;
         `OFS_SETUP_TWO: n.setup_two = d;
         `OFS_SETUP_THREE: n.setup_three = d;
         `OFS_OFFSET_CANCEL_SETUP: n.offset_cancel_setup = d;
         `OFS_INTERRUPT_MASK_BITS: n.interrupt_mask_bits = d;
         default: n = s;
      endcase
      return n;
   endfunction

   // fetch the byte at the pointer, start shifting it out, step the pointer
   function automatic port_state_t load_byte(input port_state_t s, input logic busy);
      port_state_t n;
      logic [7:0] d;
      d = reg_read(s, s.ptr, busy);
      n = latch_pair(s, s.ptr);
      n.shift = d;
      // a zero bit pulls the line; a one leaves it to the pull-up
      n.sda_oe = ~d[7];
      n.bits = 4'h0;
      n.ptr = s.ptr + 8'h01;
      n.st = ST_READ;
      return n;
   endfunction

   // ************************************************
   // link state machine and measurement control
   // ************************************************
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   always_comb begin
      // edges and bus conditions come from the synchronised pair only
      scl_rise = scl_s & ~s_r.scl_q;
      scl_fall = ~scl_s & s_r.scl_q;
      start_seen = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
      stop_seen = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;
      s_nxt = s_r;
      s_nxt.scl_q = scl_s;
      s_nxt.sda_q = sda_s;
      if (start_seen) begin
         // plain or repeated start; the pointer is left alone
         s_nxt.st = ST_ADDR;
         s_nxt.bits = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop_seen) begin
         s_nxt.st = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         case (s_r.st)
            ST_IDLE: begin
               s_nxt.sda_oe = 1'b0;
            end
            ST_ADDR, ST_WRITE: begin
               if (scl_rise) begin
                  s_nxt.shift = {s_r.shift[6:0], sda_s};
                  s_nxt.bits = s_r.bits + 4'h1;
               end else if (scl_fall && s_r.bits == 4'h8) begin
                  if (s_r.st == ST_ADDR) begin
                     if (s_r.shift[7:1] == SLAVE_ADDR) begin
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.rw = s_r.shift[0];
                        s_nxt.pointer_byte = ~s_r.shift[0];
                        s_nxt.st = ST_ADDR_ACK;
                     end else begin
                        s_nxt.st = ST_IDLE;
                     end
                  end else begin
                     // every written byte is acked, read-only targets too
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st = ST_WRITE_ACK;
                     if (s_r.pointer_byte) begin
                        s_nxt.ptr = s_r.shift;
                        s_nxt.pointer_byte = 1'b0;
                     end else begin
                        s_nxt = reg_write(s_nxt, s_r.ptr, s_r.shift);
                        s_nxt.ptr = s_r.ptr + 8'h01;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (s_r.rw) begin
                     // no pointer byte: carry on from the stored pointer
                     s_nxt = load_byte(s_nxt, tif.busy);
                  end else begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.bits = 4'h0;
                     s_nxt.st = ST_WRITE;
                  end
               end
            end
            ST_WRITE_ACK: begin
               if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.bits = 4'h0;
                  s_nxt.st = ST_WRITE;
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  // the eighth fall hands the line back for the master's answer
                  if (s_r.bits == 4'h7) begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = ST_READ_ACK;
                  end else begin
                     s_nxt.shift = {s_r.shift[6:0], 1'b0};
                     s_nxt.sda_oe = ~s_r.shift[6];
                     s_nxt.bits = s_r.bits + 4'h1;
                  end
               end
            end
            ST_READ_ACK: begin
               if (scl_rise) begin
                  s_nxt.master_ack = ~sda_s;
               end else if (scl_fall) begin
                  if (s_r.master_ack) begin
                     s_nxt = load_byte(s_nxt, tif.busy);
                  end else begin
                     // bus released; wait for stop or repeated start
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.st = ST_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      // results are captured when an integration ends
      if (tif.done) begin
         s_nxt.res_z = i_z_result;
         s_nxt.res_y = i_y_result;
         s_nxt.res_ir1 = i_infrared_one;
         s_nxt.res_ch4 = s_nxt.setup_one[`BIT_CH4_SELECT_IR2] ?
                         i_second_infrared_channel : i_x_result;
      end
      // a capture in the cycle power drops still sets the flag: set wins over clear
      if (tif.done) begin
         s_nxt.valid = 1'b1;
      end else if (!s_r.state_enable[`BIT_POWER_ON]) begin
         s_nxt.valid = 1'b0;
      end
      // 128x shares the 64x code and is picked by a bit of setup_two
      case (s_nxt.setup_one[`FLD_GAIN])
         2'h0: s_nxt.analog_gain_select = 3'h0;
         2'h1: s_nxt.analog_gain_select = 3'h1;
         2'h2: s_nxt.analog_gain_select = 3'h2;
         2'h3: s_nxt.analog_gain_select =
                  s_nxt.setup_two[`BIT_GAIN_HIGH] ? 3'h4 : 3'h3;
         default: s_nxt.analog_gain_select = 3'h0;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
         // bus history starts idle so no false start follows reset
         s_r.scl_q <= 1'b1;
         s_r.sda_q <= 1'b1;
         s_r.setup_zero <= `RST_SETUP_ZERO;
         s_r.setup_two <= `RST_SETUP_TWO;
         s_r.setup_three <= `RST_SETUP_THREE;
         s_r.offset_cancel_setup <= `RST_OFFSET_CANCEL_SETUP;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   // the timebase only runs with power on; measuring needs both enable bits
   // it lingers for the one cycle the timer needs to let go after power-off
   assign o_osc_run = s_r.state_enable[`BIT_POWER_ON] | tif.busy;
   assign tif.run = s_r.state_enable[`BIT_POWER_ON] &
                    s_r.state_enable[`BIT_MEASURE_ENABLE];
   assign tif.length = s_r.integration_length;
   assign o_integrating = tif.busy;
   assign o_capture = tif.done;
   assign o_analog_gain_select = s_r.analog_gain_select;
   // open drain: the pad only ever pulls low
   assign o_sda = 1'b0;
   assign o_sda_oe = s_r.sda_oe;
endmodule
`default_nettype wire

// ===== light_sensor_defines.svh
`ifndef LIGHT_SENSOR_DEFINES_SVH
`define LIGHT_SENSOR_DEFINES_SVH
// ************************************************
// register offsets
// ************************************************
`define OFS_STATE_ENABLE 8'h80
`define OFS_INTEGRATION_LENGTH 8'h81
`define OFS_IDLE_GAP_LENGTH 8'h83
`define OFS_LOW_THRESHOLD_LSB 8'h84
`define OFS_LOW_THRESHOLD_MSB 8'h85
`define OFS_HIGH_THRESHOLD_LSB 8'h86
`define OFS_HIGH_THRESHOLD_MSB 8'h87
`define OFS_ALERT_FILTER_COUNT 8'h8C
`define OFS_SETUP_ZERO 8'h8D
`define OFS_SETUP_ONE 8'h90
`define OFS_REVISION_CODE 8'h91
`define OFS_PART_CODE 8'h92
`define OFS_DEVICE_STATUS 8'h93
`define OFS_Z_RESULT_LSB 8'h94
`define OFS_Z_RESULT_MSB 8'h95
`define OFS_Y_RESULT_LSB 8'h96
`define OFS_Y_RESULT_MSB 8'h97
`define OFS_INFRARED_ONE_LSB 8'h98
`define OFS_INFRARED_ONE_MSB 8'h99
`define OFS_X_OR_INFRARED_TWO_LSB 8'h9A
`define OFS_X_OR_INFRARED_TWO_MSB 8'h9B
`define OFS_SETUP_TWO 8'h9F
`define OFS_SETUP_THREE 8'hAB
`define OFS_OFFSET_CANCEL_SETUP 8'hD6
`define OFS_INTERRUPT_MASK_BITS 8'hDD
// ************************************************
// reset values and fields
// ************************************************
`define RST_SETUP_ZERO 8'h80
`define RST_SETUP_TWO 8'h04
`define RST_SETUP_THREE 8'h0C
`define RST_OFFSET_CANCEL_SETUP 8'h7F
`define BIT_POWER_ON 0
`define BIT_MEASURE_ENABLE 1
`define BIT_CH4_SELECT_IR2 3
`define BIT_GAIN_HIGH 4
`define FLD_GAIN 1:0
// ************************************************
// timing
// ************************************************
`define SYS_CLK_MHZ 40.0
`define INTEG_STEP_MS 2.78
`endif

// ===== light_sensor_pkg.sv
`default_nettype none
package light_sensor_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
   } link_state_t;
   typedef struct packed {
      link_state_t st;
      logic sda_q;
      logic scl_q;
      logic [3:0] bits;
      logic [7:0] shift;
      logic rw;
      logic pointer_byte;
      logic master_ack;
      logic sda_oe;
      logic [7:0] ptr;
      logic [7:0] state_enable;
      logic [7:0] integration_length;
      logic [7:0] idle_gap_length;
      logic [7:0] alert_filter_count;
      logic [7:0] setup_zero;
      logic [7:0] setup_one;
      logic [7:0] setup_two;
      logic [7:0] setup_three;
      logic [7:0] offset_cancel_setup;
      logic [7:0] interrupt_mask_bits;
      logic [15:0] low_threshold;
      logic [15:0] high_threshold;
      logic [7:0] write_hold;
      logic [7:0] read_latch;
      logic [15:0] res_z;
      logic [15:0] res_y;
      logic [15:0] res_ir1;
      logic [15:0] res_ch4;
      logic valid;
      logic [2:0] analog_gain_select;
   } port_state_t;
   typedef struct packed {
      logic meta;
      logic stable;
   } sync_state_t;
   typedef struct packed {
      logic [16:0] pre;
      logic [7:0] steps;
      logic busy;
      logic done;
   } timer_state_t;
endpackage
`default_nettype wire

// ===== step_timer_if.sv
`default_nettype none
interface step_timer_if;
   logic run;
   logic [7:0] length;
   logic done;
   logic busy;
   modport ctrl (output run, output length, input done, input busy);
   modport tmr (input run, input length, output done, output busy);
endinterface
`default_nettype wire

// ===== sync_two_flop.sv
`default_nettype none
module sync_two_flop #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // level in and out
   input wire logic i_async,
   output logic o_sync
);
   import light_sensor_pkg::*;
   sync_state_t s_r;
   sync_state_t s_nxt;
   always_comb begin
      s_nxt.meta = i_async;
      s_nxt.stable = s_r.meta;
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= {RESET_LEVEL, RESET_LEVEL};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_sync = s_r.stable;
endmodule
`default_nettype wire

// ===== step_timer.sv
`default_nettype none
`include "light_sensor_defines.svh"
module step_timer #(
   parameter int STEP_CYCLES = 111200
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // control
   step_timer_if.tmr tif
);
   import light_sensor_pkg::*;
   localparam logic [16:0] PRE_LAST = 17'(STEP_CYCLES - 1);
   timer_state_t s_r;
   timer_state_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!tif.run) begin
         s_nxt = '0;
      end else if (!s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.steps = tif.length;
         s_nxt.pre = '0;
      end else if (s_r.pre == PRE_LAST) begin
         // one step of the measurement clock elapsed
         s_nxt.pre = '0;
         if (s_r.steps == 8'h00) begin
            // terminal count: length N gives N+1 steps, then reload
            s_nxt.done = 1'b1;
            s_nxt.steps = tif.length;
         end else begin
            s_nxt.steps = s_r.steps - 8'h01;
         end
      end else begin
         s_nxt.pre = s_r.pre + 17'h00001;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign tif.done = s_r.done;
   assign tif.busy = s_r.busy;
endmodule
`default_nettype wire

// ===== light_sensor_monitor.sv
`default_nettype none
module light_sensor_monitor #(
   parameter int STEP_CYCLES = 8
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // link and control
   input wire logic i_scl,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic o_osc_run,
   input wire logic o_integrating,
   input wire logic o_capture,
   input wire logic [2:0] o_analog_gain_select
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap_r;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // cycles since the last capture; restarts whenever integration is off
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         gap_r <= 0;
      end else if (o_capture || !o_integrating) begin
         gap_r <= 0;
      end else begin
         gap_r <= gap_r + 1;
      end
   end
   // ****
   // properties
   // ****
   // a pull on the line lasts a whole bit or acknowledge, never a short glitch
   property p_sda_val; $rose(o_sda_oe) |-> o_sda == 1'b0 ##1 o_sda_oe [*6]; endproperty
   a_sda_val: assert property (p_sda_val) else $error("sda pull too short");
   property p_oe_edge; $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2); endproperty
   a_oe_edge: assert property (p_oe_edge) else $error("sda enable moved in high scl");
   property p_osc_edge; $changed(o_osc_run) |-> !$past(i_scl, 2); endproperty
   a_osc_edge: assert property (p_osc_edge) else $error("osc run moved off a byte");
   property p_gain_edge; $changed(o_analog_gain_select) |-> !$past(i_scl, 2); endproperty
   a_gain_edge: assert property (p_gain_edge) else $error("gain moved off a byte");
   property p_gain_max; o_analog_gain_select <= 3'h4; endproperty
   a_gain_max: assert property (p_gain_max) else $error("gain code out of range");
   property p_integ_osc; o_integrating |-> o_osc_run; endproperty
   a_integ_osc: assert property (p_integ_osc) else $error("integrating without osc");
   property p_cap_pulse; o_capture |=> !o_capture; endproperty
   a_cap_pulse: assert property (p_cap_pulse) else $error("capture longer than one");
   property p_cap_gap; o_capture |-> gap_r >= STEP_CYCLES - 1 && o_integrating; endproperty
   a_cap_gap: assert property (p_cap_gap) else $error("capture before one step");
   property p_rst_out;
      $rose(i_rstn) |-> !o_sda_oe && !o_osc_run && o_analog_gain_select == 3'h0;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
   c_cap: cover property (o_capture);
   c_ack: cover property ($rose(o_sda_oe));
   c_gain: cover property (o_analog_gain_select == 3'h4);
endmodule
bind light_sensor_i2c_register_port light_sensor_monitor #(.STEP_CYCLES(STEP_CYCLES)) i_mon (
   .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_scl(i_scl), .o_sda(o_sda),
   .o_sda_oe(o_sda_oe), .o_osc_run(o_osc_run), .o_integrating(o_integrating),
   .o_capture(o_capture), .o_analog_gain_select(o_analog_gain_select));
`default_nettype wire

// ===== i2c_master_model.sv
`default_nettype none
module i2c_master_model (
   // link pins
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   // scl stands high and sda is released between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // ****
   // bus conditions, 200 ns clock, phase unrelated to the system clock
   // ****
   task automatic start();
      #7 o_sda = 1'b1;
      #50 o_scl = 1'b1;
      #50 o_sda = 1'b0;
      #50 o_scl = 1'b0;
      #50;
   endtask
   task automatic stop();
      o_sda = 1'b0;
      #50 o_scl = 1'b1;
      #50 o_sda = 1'b1;
      #50;
   endtask
   // eight bits msb first, then the ninth; a one leaves the line to the device
   task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
         output logic ack);
      logic [8:0] s;
      s = {d, a_in};
      for (int i = 8; i >= 0; i--) begin
         o_sda = s[i];
         #50 o_scl = 1'b1;
         #50 s[i] = i_sda_wire;
         #50 o_scl = 1'b0;
         #50;
      end
      q = s[8:1];
      ack = s[0];
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADDR = 7'h2A;
   localparam int STEP = 8;
   logic clk, rstn, oe, sda_o, osc, integ, cap;
   logic [2:0] gain;
   logic [15:0] zr, yr, ir1, xr, ir2;
   wire scl, sda_m, sda_w;
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] rq[$];
   // pulled-up open drain line: low while either party pulls
   assign sda_w = (oe ? sda_o : 1'b1) & sda_m;
   light_sensor_i2c_register_port #(.SLAVE_ADDR(ADDR), .STEP_CYCLES(STEP)) i_dut (
      .i_clk_sys(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o),
      .o_sda_oe(oe), .i_z_result(zr), .i_y_result(yr), .i_infrared_one(ir1),
      .i_x_result(xr), .i_second_infrared_channel(ir2), .o_osc_run(osc),
      .o_integrating(integ), .o_capture(cap), .o_analog_gain_select(gain));
   i2c_master_model i_bus (.o_scl(scl), .o_sda(sda_m), .i_sda_wire(sda_w));
   // ****
   // shared tasks
   // ****
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic addr(input logic rw);
      logic [7:0] q;
      logic a;
      i_bus.start();
      i_bus.xfer({ADDR, rw}, 1'b1, q, a);
      chk("address ack", 1'b0, a);
   endtask
   task automatic wr(input logic [7:0] p, input int n, input logic [31:0] d);
      logic [7:0] q;
      logic a;
      addr(1'b0);
      i_bus.xfer(p, 1'b1, q, a);
      chk("pointer ack", 1'b0, a);
      for (int i = 0; i < n; i++) begin
         i_bus.xfer(d[8*i +: 8], 1'b1, q, a);
         chk("data ack", 1'b0, a);
      end
      i_bus.stop();
   endtask
   task automatic rd(input logic setp, input logic [7:0] p, input int n);
      logic [7:0] q;
      logic a;
      rq.delete();
      if (setp) begin
         addr(1'b0);
         i_bus.xfer(p, 1'b1, q, a);
      end
      addr(1'b1);
      for (int i = 0; i < n; i++) begin
         i_bus.xfer(8'hFF, i == n - 1, q, a);
         rq.push_back(q);
      end
      i_bus.stop();
   endtask
   task automatic wcap(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (cap !== 1'b1 && n < 400);
      if (n >= 400) begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      logic [15:0] t[7] = '{16'h8D80, 16'h9F04, 16'hAB0C, 16'hD67F, 16'h8000, 16'h8100,
         16'hDD00};
      foreach (t[i]) begin
         rd(1'b1, t[i][15:8], 1);
         chk("reset value", t[i][7:0], rq[0]);
      end
      rd(1'b1, 8'h91, 1);
      chk("revision", 8'h5A, rq[0]);
      rd(1'b0, 8'h00, 1);
      chk("resumed read", 8'hA5, rq[0]);
      $display("reset test done");
   endtask
   task automatic t_write();
      wr(8'h81, 3, 32'h0033_2211);
      rd(1'b1, 8'h81, 3);
      chk("burst 0x81", 8'h11, rq[0]);
      chk("unmapped", 8'h00, rq[1]);
      chk("burst 0x83", 8'h33, rq[2]);
      wr(8'h91, 1, 32'h0);
      rd(1'b1, 8'h91, 1);
      chk("read-only", 8'h5A, rq[0]);
      wr(8'h84, 4, 32'h7856_3412);
      rd(1'b1, 8'h84, 4);
      for (int i = 0; i < 4; i++) begin
         chk("threshold", 8'h12 + 8'h22 * i, rq[i]);
      end
      $display("write test done");
   endtask
   task automatic t_measure();
      logic [63:0] e;
      int n;
      e = {ir2, ir1, yr, zr};
      wr(8'h90, 1, 32'h0B);
      wr(8'h9F, 1, 32'h14);
      chk("gain 128x", 3'h4, gain);
      wr(8'h81, 1, 32'h01);
      wr(8'h80, 1, 32'h03);
      chk("osc run", 1'b1, osc);
      chk("integrating", 1'b1, integ);
      wcap(n);
      wcap(n);
      chk("integration cycles", 2 * STEP, n);
      rd(1'b1, 8'h93, 1);
      chk("status", 8'h03, rq[0]);
      rd(1'b1, 8'h94, 8);
      for (int i = 0; i < 8; i++) begin
         chk("result", e[8*i +: 8], rq[i]);
      end
      rd(1'b1, 8'h94, 1);
      @(posedge clk) zr <= 16'hAAAA;
      wcap(n);
      wcap(n);
      rd(1'b1, 8'h95, 1);
      chk("latched half", e[15:8], rq[0]);
      wr(8'h90, 1, 32'h03);
      wcap(n);
      wcap(n);
      rd(1'b1, 8'h9A, 2);
      chk("x low", xr[7:0], rq[0]);
      chk("x high", xr[15:8], rq[1]);
      wr(8'h80, 1, 32'h00);
      chk("osc stopped", 1'b0, osc);
      chk("integ stopped", 1'b0, integ);
      $display("measure test done");
   endtask
   task automatic t_gain();
      logic [7:0] q;
      logic a;
      wr(8'h9F, 1, 32'h04);
      for (int g = 0; g < 4; g++) begin
         wr(8'h90, 1, g);
         chk("gain code", g, gain);
      end
      i_bus.start();
      i_bus.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
      chk("foreign address", 1'b1, a);
      i_bus.stop();
      $display("gain and address test done");
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      zr = 16'h1234;
      yr = 16'h5678;
      ir1 = 16'h9ABC;
      xr = 16'hDEF0;
      ir2 = 16'h0F1E;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_write();
      t_measure();
      t_gain();
      conclude();
   end
endmodule
`default_nettype wire
